// [hw/psm_pkg.sv]
package psm_pkg;

  // Object indices on the host object port
  localparam logic [15:0] IDX_CMD_WORD    = 16'h6040;
  localparam logic [15:0] IDX_REPORT_WORD = 16'h6041;
  localparam logic [15:0] IDX_MODE_REQ    = 16'h6060;
  localparam logic [15:0] IDX_MODE_FORCE  = 16'h6061;

  // Reset values
  localparam logic [15:0] CMD_WORD_RST = 16'h0000;
  localparam logic [7:0]  MODE_RST     = 8'h00;

  // Command word bit positions
  localparam int unsigned CW_FAULT_RST_BIT = 7;
  localparam int unsigned CW_HALT_BIT      = 8;

  // Command patterns as mask and value over bits 7 and 3..0
  localparam logic [15:0] PAT_SHUTDOWN_M  = 16'h0087;
  localparam logic [15:0] PAT_SHUTDOWN_V  = 16'h0006;
  localparam logic [15:0] PAT_SWITCH_M    = 16'h008F;
  localparam logic [15:0] PAT_SWITCH_V    = 16'h0007;
  localparam logic [15:0] PAT_DISVOLT_M   = 16'h0082;
  localparam logic [15:0] PAT_DISVOLT_V   = 16'h0000;
  localparam logic [15:0] PAT_QSTOP_M     = 16'h0086;
  localparam logic [15:0] PAT_QSTOP_V     = 16'h0002;
  localparam logic [15:0] PAT_ENABLE_M    = 16'h008F;
  localparam logic [15:0] PAT_ENABLE_V    = 16'h000F;

  // Report word codes, don't-care bits driven as zero
  localparam logic [15:0] SW_NOT_READY = 16'h0000;
  localparam logic [15:0] SW_SO_DIS    = 16'h0040;
  localparam logic [15:0] SW_READY     = 16'h0021;
  localparam logic [15:0] SW_SWITCHED  = 16'h0023;
  localparam logic [15:0] SW_OP_EN     = 16'h0027;
  localparam logic [15:0] SW_QSTOP     = 16'h0007;
  localparam logic [15:0] SW_FREACT    = 16'h000F;
  localparam logic [15:0] SW_FAULT     = 16'h0008;

  // Operating modes in which the halt bit acts
  localparam logic [7:0] MODE_PROF_POS  = 8'h01;
  localparam logic [7:0] MODE_VELOCITY  = 8'h02;
  localparam logic [7:0] MODE_PROF_VEL  = 8'h03;
  localparam logic [7:0] MODE_PROF_TRQ  = 8'h04;
  localparam logic [7:0] MODE_INTERP    = 8'h07;

  // Power states, one-hot
  typedef enum logic [7:0] {
    ST_NOT_READY = 8'h01,
    ST_SO_DIS    = 8'h02,
    ST_READY     = 8'h04,
    ST_SWITCHED  = 8'h08,
    ST_OP_EN     = 8'h10,
    ST_QSTOP     = 8'h20,
    ST_FREACT    = 8'h40,
    ST_FAULT     = 8'h80
  } psm_state_t;

endpackage : psm_pkg

// [hw/psm_cmd_if.sv]
`timescale 1ns/1ns
// Decoded command requests from the decoder to the state machine
interface psm_cmd_if;
  logic shutdown;     // Pattern x110
  logic switch_on;    // Pattern 0111
  logic dis_volt;     // Bit 1 low
  logic quick_stop;   // Bit 2 low, bit 1 high
  logic enable_op;    // Pattern 1111 as a level
  logic enable_rise;  // Pattern 1111 just appeared
  logic fault_rise;   // Bit 7 just rose
  logic halt_req;     // Bit 8 level

  modport dec (output shutdown, switch_on, dis_volt, quick_stop, enable_op, enable_rise, fault_rise, halt_req);
  modport fsm (input  shutdown, switch_on, dis_volt, quick_stop, enable_op, enable_rise, fault_rise, halt_req);
endinterface : psm_cmd_if

// [hw/psm_cmd_decode.sv]
`timescale 1ns/1ns
// Turns the command word into requests; keeps last-cycle levels for edges
module psm_cmd_decode (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [15:0] cmd_i,
  psm_cmd_if.dec           req
);

  typedef struct packed {
    logic en_q;   // Enable pattern seen last cycle
    logic rst_q;  // Fault-reset bit seen last cycle
  } psm_dec_t;

  psm_dec_t s_q;
  psm_dec_t s_d;

  // Masked compare, shared by every pattern
  function automatic logic pat(input logic [15:0] w, input logic [15:0] m, input logic [15:0] v);
    return (w & m) == v;
  endfunction : pat

  // Pattern decode; bit 7 high masks every ordinary command
  always_comb begin
    req.shutdown    = pat(cmd_i, psm_pkg::PAT_SHUTDOWN_M, psm_pkg::PAT_SHUTDOWN_V);
    req.switch_on   = pat(cmd_i, psm_pkg::PAT_SWITCH_M, psm_pkg::PAT_SWITCH_V);
    req.enable_op   = pat(cmd_i, psm_pkg::PAT_ENABLE_M, psm_pkg::PAT_ENABLE_V);
    req.dis_volt    = pat(cmd_i, psm_pkg::PAT_DISVOLT_M, psm_pkg::PAT_DISVOLT_V);
    req.quick_stop  = pat(cmd_i, psm_pkg::PAT_QSTOP_M, psm_pkg::PAT_QSTOP_V);
    // Only a fresh appearance counts, a held level does nothing
    req.enable_rise = req.enable_op & ~s_q.en_q;
    req.fault_rise  = cmd_i[psm_pkg::CW_FAULT_RST_BIT] & ~s_q.rst_q;
    req.halt_req    = cmd_i[psm_pkg::CW_HALT_BIT];
    s_d.en_q        = req.enable_op;
    s_d.rst_q       = cmd_i[psm_pkg::CW_FAULT_RST_BIT];
  end

  // Edge history
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Edge judged from the command word itself, so a broken history register shows up
  a_edge_once: assert property (@(posedge clk_i) disable iff (rst_i)
    req.enable_rise == (((cmd_i & psm_pkg::PAT_ENABLE_M) == psm_pkg::PAT_ENABLE_V) &&
    (($past(cmd_i) & psm_pkg::PAT_ENABLE_M) != psm_pkg::PAT_ENABLE_V))) else $error("enable edge wrong");

endmodule : psm_cmd_decode

// [hw/psm_top.sv]
`timescale 1ns/1ns
// Operation
// - Commands via command word, state via report
// - Decode shutdown, switch on, enable patterns
// - Bit1 low disables voltage; bit2 low quick-stops
// - Quick stop to enabled only on edge
// - Fault reset on rising edge only
// - Report word encodes each power state
// - Self-test passed enters switch-on disabled
// - Unrecoverable error locks in not ready
// - Mode requested and mode in force separate
// - Mode write accepted in every state
// - Halt bit triggers halt in halting modes, in operation enabled only
module psm_top (
  input  wire logic        CLOCK_I,
  input  wire logic        RST_I,
  input  wire logic        SELFTEST_OK_I,     // Self-test passed, asynchronous level
  input  wire logic        FAULT_I,           // Recoverable fault, asynchronous level
  input  wire logic        FATAL_I,           // Unrecoverable error, asynchronous level
  input  wire logic        FAULT_DONE_I,      // Fault reaction finished, asynchronous level
  input  wire logic        OBJ_WE_I,          // Object write strobe
  input  wire logic        OBJ_RE_I,          // Object read strobe
  input  wire logic [15:0] OBJ_INDEX_I,       // Object index
  input  wire logic [15:0] OBJ_WDATA_I,       // Write data
  output logic      [15:0] OBJ_RDATA_O,       // Read data
  output logic             OBJ_ACK_O,         // Access done
  output logic             OBJ_ERR_O,         // Unknown or read-only target
  output logic             HALT_O,            // Halt braking reaction requested
  output logic             OPERATE_O          // Operation enabled
);

  // Whole module state
  typedef struct packed {
    logic [3:0]          sync1;     // First synchroniser stage
    logic [3:0]          sync2;     // Second synchroniser stage
    psm_pkg::psm_state_t st;        // Power state
    logic                lock;      // Unrecoverable error seen
    logic [15:0]         cmd;       // Command word object
    logic [7:0]          mode_req;  // Requested mode object
    logic [7:0]          mode_act;  // Mode in force
    logic                ack;       // Access answer
    logic                err;       // Access refused
    logic [15:0]         rdata;     // Read answer
    logic                halt;      // Halt output
  } psm_top_t;

  psm_top_t s_q;
  psm_top_t s_d;

  psm_cmd_if req ();

  // Synchronised pins
  logic selftest_s;
  logic fault_s;
  logic fatal_s;
  logic fdone_s;
  logic quiet;
  logic [15:0] report;

  assign selftest_s = s_q.sync2[0];
  assign fault_s    = s_q.sync2[1];
  assign fatal_s    = s_q.sync2[2];
  assign fdone_s    = s_q.sync2[3];
  assign quiet      = !fatal_s && !fault_s;

  psm_cmd_decode u_dec (
    .clk_i (CLOCK_I),
    .rst_i (RST_I),
    .cmd_i (s_q.cmd),
    .req   (req)
  );

  // Modes in which the halt bit has meaning
  function automatic logic halt_mode(input logic [7:0] m);
    return (m == psm_pkg::MODE_PROF_POS) || (m == psm_pkg::MODE_VELOCITY) ||
           (m == psm_pkg::MODE_PROF_VEL) || (m == psm_pkg::MODE_PROF_TRQ) ||
           (m == psm_pkg::MODE_INTERP);
  endfunction : halt_mode

  // Report word from the state, the only view of the state to the host
  always_comb begin
    case (s_q.st)
      psm_pkg::ST_NOT_READY: report = psm_pkg::SW_NOT_READY;
      psm_pkg::ST_SO_DIS:    report = psm_pkg::SW_SO_DIS;
      psm_pkg::ST_READY:     report = psm_pkg::SW_READY;
      psm_pkg::ST_SWITCHED:  report = psm_pkg::SW_SWITCHED;
      psm_pkg::ST_OP_EN:     report = psm_pkg::SW_OP_EN;
      psm_pkg::ST_QSTOP:     report = psm_pkg::SW_QSTOP;
      psm_pkg::ST_FREACT:    report = psm_pkg::SW_FREACT;
      psm_pkg::ST_FAULT:     report = psm_pkg::SW_FAULT;
      default:               report = psm_pkg::SW_NOT_READY;
    endcase
  end

  // Next state: sync, object port, power state machine
  always_comb begin
    s_d       = s_q;
    s_d.sync1 = {FAULT_DONE_I, FATAL_I, FAULT_I, SELFTEST_OK_I};
    s_d.sync2 = s_q.sync1;
    s_d.ack   = OBJ_WE_I | OBJ_RE_I;
    s_d.err   = 1'b0;
    s_d.rdata = '0;
    // Object writes; only the two writable objects take data
    if (OBJ_WE_I) begin
      case (OBJ_INDEX_I)
        psm_pkg::IDX_CMD_WORD: s_d.cmd      = OBJ_WDATA_I;
        psm_pkg::IDX_MODE_REQ: s_d.mode_req = OBJ_WDATA_I[7:0];
        default:               s_d.err      = 1'b1;
      endcase
    end else if (OBJ_RE_I) begin
      case (OBJ_INDEX_I)
        psm_pkg::IDX_CMD_WORD:    s_d.rdata = s_q.cmd;
        psm_pkg::IDX_REPORT_WORD: s_d.rdata = report;
        psm_pkg::IDX_MODE_REQ:    s_d.rdata = {8'h00, s_q.mode_req};
        psm_pkg::IDX_MODE_FORCE:  s_d.rdata = {8'h00, s_q.mode_act};
        default:                  s_d.err   = 1'b1;
      endcase
    end
    // Mode changes take effect whatever the power state
    s_d.mode_act = s_q.mode_req;
    // Power state machine; fatal beats fault beats commands
    if (fatal_s || s_q.lock) begin
      s_d.lock = 1'b1;
      s_d.st   = psm_pkg::ST_NOT_READY;
    end else if (fault_s && !(s_q.st inside {psm_pkg::ST_NOT_READY, psm_pkg::ST_FREACT, psm_pkg::ST_FAULT})) begin
      s_d.st = psm_pkg::ST_FREACT;
    end else begin
      case (s_q.st)
        psm_pkg::ST_NOT_READY: begin
          if (selftest_s) s_d.st = psm_pkg::ST_SO_DIS;
        end
        psm_pkg::ST_SO_DIS: begin
          if (req.shutdown) s_d.st = psm_pkg::ST_READY;
        end
        psm_pkg::ST_READY: begin
          if (req.dis_volt || req.quick_stop) s_d.st = psm_pkg::ST_SO_DIS;
          else if (req.switch_on) s_d.st = psm_pkg::ST_SWITCHED;
        end
        psm_pkg::ST_SWITCHED: begin
          if (req.dis_volt || req.quick_stop) s_d.st = psm_pkg::ST_SO_DIS;
          else if (req.shutdown) s_d.st = psm_pkg::ST_READY;
          else if (req.enable_op) s_d.st = psm_pkg::ST_OP_EN;
        end
        psm_pkg::ST_OP_EN: begin
          if (req.dis_volt) s_d.st = psm_pkg::ST_SO_DIS;
          else if (req.quick_stop) s_d.st = psm_pkg::ST_QSTOP;
          else if (req.shutdown) s_d.st = psm_pkg::ST_READY;
          else if (req.switch_on) s_d.st = psm_pkg::ST_SWITCHED;
        end
        psm_pkg::ST_QSTOP: begin
          // A held enable pattern must not leave quick stop
          if (req.dis_volt) s_d.st = psm_pkg::ST_SO_DIS;
          else if (req.enable_rise) s_d.st = psm_pkg::ST_OP_EN;
        end
        psm_pkg::ST_FREACT: begin
          if (fdone_s) s_d.st = psm_pkg::ST_FAULT;
        end
        psm_pkg::ST_FAULT: begin
          // Reset edges elsewhere are dropped, not remembered
          if (req.fault_rise && !fault_s) s_d.st = psm_pkg::ST_SO_DIS;
        end
        default: s_d.st = psm_pkg::ST_NOT_READY;
      endcase
    end
    s_d.halt = req.halt_req && halt_mode(s_q.mode_act) && (s_q.st == psm_pkg::ST_OP_EN);
  end

  // State register
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      s_q          <= '0;
      s_q.st       <= psm_pkg::ST_NOT_READY;
      s_q.cmd      <= psm_pkg::CMD_WORD_RST;
      s_q.mode_req <= psm_pkg::MODE_RST;
      s_q.mode_act <= psm_pkg::MODE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign OBJ_RDATA_O = s_q.rdata;
  assign OBJ_ACK_O   = s_q.ack;
  assign OBJ_ERR_O   = s_q.err;
  assign HALT_O      = s_q.halt;
  assign OPERATE_O   = (s_q.st == psm_pkg::ST_OP_EN);

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);

  a_report_read: assert property ((OBJ_RE_I && !OBJ_WE_I && OBJ_INDEX_I == psm_pkg::IDX_REPORT_WORD) |=>
    OBJ_ACK_O && OBJ_RDATA_O == $past(report)) else $error("report read wrong");
  a_report_code: assert property ((s_q.st == psm_pkg::ST_QSTOP) |-> report[6:5] == 2'b00 &&
    report[3:0] == 4'h7) else $error("quick stop code wrong");
  a_selftest_entry: assert property ((s_q.st == psm_pkg::ST_NOT_READY && !s_q.lock && selftest_s &&
    !fatal_s) |=> s_q.st == psm_pkg::ST_SO_DIS) else $error("self-test entry missed");
  a_fatal_lock: assert property (fatal_s |=> s_q.st == psm_pkg::ST_NOT_READY [*8])
    else $error("left not ready after fatal");
  a_shutdown_go: assert property ((quiet && req.shutdown && s_q.st inside {psm_pkg::ST_SO_DIS,
    psm_pkg::ST_SWITCHED, psm_pkg::ST_OP_EN}) |=> s_q.st == psm_pkg::ST_READY) else $error("shutdown ignored");
  a_dis_volt: assert property ((quiet && req.dis_volt && s_q.st inside {psm_pkg::ST_READY,
    psm_pkg::ST_SWITCHED, psm_pkg::ST_OP_EN, psm_pkg::ST_QSTOP}) |=> s_q.st == psm_pkg::ST_SO_DIS)
    else $error("voltage disable ignored");
  a_qstop_hold: assert property ((quiet && s_q.st == psm_pkg::ST_QSTOP && !req.enable_rise) |=>
    s_q.st != psm_pkg::ST_OP_EN) else $error("quick stop left without edge");
  a_fault_reset: assert property ((s_q.st == psm_pkg::ST_FAULT && !fatal_s) |->
    ##1 (s_q.st == psm_pkg::ST_SO_DIS) == $past(req.fault_rise && !fault_s)) else $error("fault reset wrong");
  a_pat_0111: assert property ((quiet && req.switch_on && s_q.st inside {psm_pkg::ST_READY,
    psm_pkg::ST_OP_EN}) |=> s_q.st == psm_pkg::ST_SWITCHED) else $error("0111 not to switched on");
  a_mode_force: assert property ((OBJ_WE_I && OBJ_INDEX_I == psm_pkg::IDX_MODE_REQ) |-> ##2
    s_q.mode_act == $past(OBJ_WDATA_I[7:0], 2)) else $error("mode not in force");
  a_halt_out: assert property ((req.halt_req && s_q.st == psm_pkg::ST_OP_EN && halt_mode(s_q.mode_act))
    |=> HALT_O) else $error("halt not raised");

  c_op_enabled: cover property (s_q.st == psm_pkg::ST_SWITCHED ##1 s_q.st == psm_pkg::ST_OP_EN);
  c_qstop_back: cover property (s_q.st == psm_pkg::ST_QSTOP ##1 s_q.st == psm_pkg::ST_OP_EN);
  c_fault_clear: cover property (s_q.st == psm_pkg::ST_FAULT ##1 s_q.st == psm_pkg::ST_SO_DIS);
  c_locked: cover property (s_q.lock);

endmodule : psm_top

// [test/psm_host_model.sv]
`timescale 1ns/1ns
// Host master on the object port: one access at a time, one-cycle strobes
module psm_host_model (
  input  wire logic        clk_i,    // Bench clock
  input  wire logic [15:0] rdata_i,  // Read data
  input  wire logic        ack_i,    // Access answered
  input  wire logic        err_i,    // Access refused
  output logic             we_o,     // Write strobe
  output logic             re_o,     // Read strobe
  output logic      [15:0] index_o,  // Object index
  output logic      [15:0] wdata_o   // Write data
);
  // Quiet port at time zero
  initial begin
    we_o    = 1'b0;
    re_o    = 1'b0;
    index_o = 16'h0000;
    wdata_o = 16'h0000;
  end

  // Idle cycles first make a slow host; zero gives back-to-back accesses
  task automatic access(input logic wr, input logic [15:0] idx, input logic [15:0] wd, input int gap,
                        output logic [15:0] rd, output logic er);
    int n;
    n = 0;
    repeat (gap) @(posedge clk_i);
    we_o    <= wr;  // State changes are only asked for by writes
    re_o    <= ~wr;
    index_o <= idx;
    wdata_o <= wd;
    @(posedge clk_i);
    we_o    <= 1'b0;
    re_o    <= 1'b0;
    index_o <= ~idx;  // Released lines change, so stale values cannot pass
    wdata_o <= ~wd;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 4);
    // A missing answer yields unknowns that any compare will catch
    rd = (ack_i === 1'b1) ? rdata_i : 16'hxxxx;
    er = (ack_i === 1'b1) ? err_i : 1'bx;
  endtask : access
endmodule : psm_host_model

// [test/tb_top.sv]
`timescale 1ns/1ns
// Self-checking bench for the drive power state machine
module tb_top;
  logic        clk, rst, selftest_ok, fault, fatal, fault_done;  // Clock, reset, status pins
  logic        we, re, ack, err, halt, operate;                  // Object port strobes, outputs
  logic [15:0] index, wdata, rdata;                              // Object port buses
  logic [31:0] seed = 32'h50cc_8f01;                             // Fixed seed, repeatable run
  int          n_fail, total_checks;                             // Verdict counters
  logic [15:0] v, m;                                             // Scratch values
  // Walk of commands with the report word each must give
  logic [15:0] walk_c [16] = '{16'h0006, 16'h0007, 16'h000F, 16'h0007, 16'h000F, 16'h000B, 16'h000F,
    16'h0006, 16'h0002, 16'h0006, 16'h0007, 16'h000F, 16'h000B, 16'h0001, 16'h0006, 16'h0007};
  logic [15:0] walk_s [16] = '{16'h0021, 16'h0023, 16'h0027, 16'h0023, 16'h0027, 16'h0007, 16'h0027,
    16'h0021, 16'h0040, 16'h0021, 16'h0023, 16'h0027, 16'h0007, 16'h0040, 16'h0021, 16'h0023};
  logic [15:0] fatal_c [4] = '{16'h0006, 16'h0080, 16'h0000, 16'h000F};  // Release attempts
  logic [7:0]  hmode [7] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h07, 8'h05, 8'h00};

  psm_top dut (.CLOCK_I(clk), .RST_I(rst), .SELFTEST_OK_I(selftest_ok), .FAULT_I(fault), .FATAL_I(fatal),
    .FAULT_DONE_I(fault_done), .OBJ_WE_I(we), .OBJ_RE_I(re), .OBJ_INDEX_I(index), .OBJ_WDATA_I(wdata),
    .OBJ_RDATA_O(rdata), .OBJ_ACK_O(ack), .OBJ_ERR_O(err), .HALT_O(halt), .OPERATE_O(operate));
  psm_host_model u_host (.clk_i(clk), .rdata_i(rdata), .ack_i(ack), .err_i(err), .we_o(we), .re_o(re),
    .index_o(index), .wdata_o(wdata));

  // Free-running 8 ns clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Xorshift step for the stimulus stream
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // Report word from bits 6,5 and the low nibble; don't-care bits read zero
  function automatic logic [15:0] sw(input logic [1:0] b65, input logic [3:0] lo);
    return {9'h000, b65, 1'b0, lo};
  endfunction : sw

  // Refusal expected for anything but a known, writable or readable object
  function automatic logic bad(input logic w, input logic [15:0] i);
    return !(i inside {psm_pkg::IDX_CMD_WORD, psm_pkg::IDX_MODE_REQ} ||
             (!w && i inside {psm_pkg::IDX_REPORT_WORD, psm_pkg::IDX_MODE_FORCE}));
  endfunction : bad

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Object write and read with a random host pace
  task automatic wr(input logic [15:0] i, input logic [15:0] d);
    logic [15:0] r;
    logic        e;
    seed = xs(seed);
    u_host.access(1'b1, i, d, int'(seed[1:0]), r, e);
    chk(16'(e), 16'(bad(1'b1, i)));
  endtask : wr

  task automatic rd(input logic [15:0] i, output logic [15:0] r);
    logic e;
    seed = xs(seed);
    u_host.access(1'b0, i, 16'h0000, int'(seed[1:0]), r, e);
    chk(16'(e), 16'(bad(1'b0, i)));
  endtask : rd

  // Command write with random unmarked bits, which must change nothing
  task automatic cmd(input logic [15:0] d);
    wr(psm_pkg::IDX_CMD_WORD, d | (seed[15:0] & 16'hFE70));
  endtask : cmd

  task automatic st(input logic [15:0] exp);
    logic [15:0] r;
    rd(psm_pkg::IDX_REPORT_WORD, r);
    chk(r, exp);
  endtask : st

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    print_verdict();
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    {selftest_ok, fault, fatal, fault_done} = 4'h0;
    n_fail = 0;
    total_checks = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    st(sw(2'b00, 4'h0));
    selftest_ok <= 1'b1;
    repeat (4) @(posedge clk);
    st(sw(2'b10, 4'h0));
    $display("test power_up done");
    // Transitions, with a random mode written in each state of the walk
    for (int i = 0; i < 16; i++) begin
      cmd(walk_c[i]);
      st(walk_s[i]);
      chk(16'(operate), 16'(walk_s[i] == sw(2'b01, 4'h7)));
      // Held apart from the seed, which every access below advances
      seed = xs(seed);
      m = seed[31:16];
      wr(psm_pkg::IDX_MODE_REQ, m);
      rd(psm_pkg::IDX_MODE_FORCE, v);
      chk(v, {8'h00, m[7:0]});
    end
    $display("test transitions done");
    wr(psm_pkg::IDX_REPORT_WORD, 16'h0000);
    wr(psm_pkg::IDX_MODE_FORCE, 16'h0001);
    wr(16'h1234, 16'h0000);
    rd(16'h1234, v);
    // Read-back of both writable objects; random unmarked command bits masked off
    rd(psm_pkg::IDX_MODE_REQ, v);
    chk(v, {8'h00, m[7:0]});
    rd(psm_pkg::IDX_CMD_WORD, v);
    chk(v & 16'h018F, 16'h0007);
    $display("test refusals done");
    // Halt bit in halting and other modes, from operation enabled
    cmd(16'h000F);
    for (int i = 0; i < 7; i++) begin
      wr(psm_pkg::IDX_MODE_REQ, {8'h00, hmode[i]});
      cmd(16'h010F);
      st(sw(2'b01, 4'h7));
      chk(16'(halt), 16'(hmode[i] inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h07}));
      cmd(16'h000F);
    end
    $display("test halt done");
    // Fault, its reaction, and reset by a bit 7 edge only
    fault <= 1'b1;
    repeat (4) @(posedge clk);
    st(sw(2'b00, 4'hF));
    fault_done <= 1'b1;
    repeat (4) @(posedge clk);
    st(sw(2'b00, 4'h8));
    cmd(16'h0080);
    st(sw(2'b00, 4'h8));
    {fault, fault_done} <= 2'b00;
    repeat (4) @(posedge clk);
    cmd(16'h0080);
    st(sw(2'b00, 4'h8));
    cmd(16'h0000);
    cmd(16'h0080);
    st(sw(2'b10, 4'h0));
    $display("test fault done");
    // Unrecoverable error: no command releases it, only a reset
    fatal <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      cmd(fatal_c[i]);
      st(sw(2'b00, 4'h0));
    end
    {rst, fatal} <= 2'b10;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    st(sw(2'b10, 4'h0));
    $display("test fatal done");
    print_verdict();
  end
endmodule : tb_top
